//--- rtl/move_literal_exec.sv
// Execution unit for literal loads, accumulator stores and indirect stores
// Assumes one instruction word per cycle, status flags held elsewhere
//
// Behaviour
// - Bank literal loads bank_select, flags untouched
// - 7-bit literal loads program counter high latch
// - 8-bit literal loads accumulator, flags untouched
// - Accumulator stored to direct file address
// - Indirect address: ptr+1, ptr-1, ptr, ptr+k
// - Pointer keeps increment/decrement, offset leaves unchanged
// - Mode codes: 00 preinc, 01 predec, 10/11 post
// - Indirect port redirects to pointer address
// - Pointer is 16-bit and wraps around
// - Pointer updates and stores leave flags alone
// - Option register loaded from accumulator
// - Software reset resets device, clears soft_reset_flag
`timescale 1ns/1ns
`default_nettype none
`include "move_literal_params.svh"

module move_literal_exec #(
  parameter int PTR_W = 16
) (
  input wire logic CORE_CLK,
  input wire logic RST_B,
  input wire logic INSTR_VALID,
  input wire logic [13:0] INSTR_WORD,
  output logic [4:0] BANK_SELECT,
  output logic [6:0] PC_HIGH_LATCH,
  output logic [7:0] ACCUM,
  output logic [7:0] OPTION_CFG,
  output logic [PTR_W-1:0] POINTER0,
  output logic [PTR_W-1:0] POINTER1,
  output logic FILE_WR_EN,
  output logic [PTR_W-1:0] FILE_WR_ADDR,
  output logic [7:0] FILE_WR_DATA,
  output logic STATUS_WR_EN,
  output logic SOFT_RESET_FLAG_B,
  output logic DEVICE_RESET_REQ,
  output logic INSTR_DONE
);

  move_literal_pkg::op_e op;
  move_literal_pkg::ptr_mode_e mode;
  logic [PTR_W-1:0] ptr_r [2];
  logic [PTR_W-1:0] ptr_nxt [2];
  logic [PTR_W-1:0] eff_addr [2];
  logic [PTR_W-1:0] ptr_new [2];
  logic ptr_sel;
  logic by_offset;
  logic [6:0] file_addr;
  logic [PTR_W-1:0] direct_addr;
  logic [4:0] bank_r;
  logic [4:0] bank_nxt;
  logic [6:0] pch_r;
  logic [6:0] pch_nxt;
  logic [7:0] acc_r;
  logic [7:0] acc_nxt;
  logic [7:0] option_r;
  logic [7:0] option_nxt;
  logic wr_en_r;
  logic wr_en_nxt;
  logic [PTR_W-1:0] wr_addr_r;
  logic [PTR_W-1:0] wr_addr_nxt;
  logic [7:0] wr_data_r;
  logic [7:0] wr_data_nxt;
  logic soft_flag_b_r;
  logic soft_flag_b_nxt;
  logic rst_req_r;
  logic rst_req_nxt;
  logic done_r;
  logic done_nxt;

  instr_decode u_decode (
    .instr(INSTR_WORD),
    .op(op)
  );

  // Operand fields of the indirect and direct store forms
  assign by_offset = (op == move_literal_pkg::OP_STORE_REL);
  assign ptr_sel = by_offset ? INSTR_WORD[`FLD_PTR_SEL_REL] : INSTR_WORD[`FLD_PTR_SEL_IND];
  assign mode = move_literal_pkg::ptr_mode_e'(INSTR_WORD[`FLD_MODE_MSB:0]);
  assign file_addr = INSTR_WORD[`FLD_FILE_MSB:0];
  // Banked linear address of a direct access
  assign direct_addr = PTR_W'({bank_r, file_addr});

  // One address calculator per indirect pointer
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_ptr
      ptr_calc #(
        .PTR_W(PTR_W)
      ) u_ptr_calc (
        .ptr(ptr_r[gi]),
        .by_offset(by_offset),
        .mode(mode),
        .offset(INSTR_WORD[`FLD_OFFSET_MSB:0]),
        .eff_addr(eff_addr[gi]),
        .ptr_new(ptr_new[gi])
      );
    end
  endgenerate

  // Next state of the core registers and the write port
  always_comb begin
    bank_nxt = bank_r;
    pch_nxt = pch_r;
    acc_nxt = acc_r;
    option_nxt = option_r;
    ptr_nxt[0] = ptr_r[0];
    ptr_nxt[1] = ptr_r[1];
    wr_en_nxt = 1'b0;
    wr_addr_nxt = wr_addr_r;
    wr_data_nxt = wr_data_r;
    soft_flag_b_nxt = soft_flag_b_r;
    rst_req_nxt = 1'b0;
    done_nxt = 1'b0;
    if (INSTR_VALID) begin
      done_nxt = (op != move_literal_pkg::OP_OTHER);
      unique case (op)
        move_literal_pkg::OP_LOAD_BANK: begin
          bank_nxt = INSTR_WORD[`FLD_BANK_MSB:0];
        end
        move_literal_pkg::OP_LOAD_PCH: begin
          pch_nxt = INSTR_WORD[`FLD_PCH_MSB:0];
        end
        move_literal_pkg::OP_LOAD_ACC: begin
          acc_nxt = INSTR_WORD[`FLD_ACC_MSB:0];
        end
        move_literal_pkg::OP_STORE: begin
          wr_en_nxt = 1'b1;
          wr_data_nxt = acc_r;
          wr_addr_nxt = direct_addr;
          if (file_addr == `ADDR_IND_PORT0) begin
            wr_addr_nxt = ptr_r[0];
          end else if (file_addr == `ADDR_IND_PORT1) begin
            wr_addr_nxt = ptr_r[1];
          end
          // Keep local copies of core registers coherent
          unique case (file_addr)
            `ADDR_PTR0_LO: ptr_nxt[0][7:0] = acc_r;
            `ADDR_PTR0_HI: ptr_nxt[0][PTR_W-1:8] = acc_r;
            `ADDR_PTR1_LO: ptr_nxt[1][7:0] = acc_r;
            `ADDR_PTR1_HI: ptr_nxt[1][PTR_W-1:8] = acc_r;
            `ADDR_BANK: bank_nxt = acc_r[4:0];
            `ADDR_ACC: acc_nxt = acc_r;
            `ADDR_PCH: pch_nxt = acc_r[6:0];
            default: begin
            end
          endcase
        end
        move_literal_pkg::OP_STORE_IND, move_literal_pkg::OP_STORE_REL: begin
          wr_en_nxt = 1'b1;
          wr_data_nxt = acc_r;
          wr_addr_nxt = eff_addr[ptr_sel];
          ptr_nxt[ptr_sel] = ptr_new[ptr_sel];
        end
        move_literal_pkg::OP_OPTION: begin
          option_nxt = acc_r;
        end
        move_literal_pkg::OP_SOFT_RESET: begin
          soft_flag_b_nxt = 1'b0;
          rst_req_nxt = 1'b1;
          bank_nxt = `RST_BANK;
          pch_nxt = `RST_PCH;
          acc_nxt = `RST_ACC;
          option_nxt = `RST_OPTION;
          ptr_nxt[0] = `RST_PTR;
          ptr_nxt[1] = `RST_PTR;
        end
        move_literal_pkg::OP_NOP, move_literal_pkg::OP_OTHER: begin
        end
      endcase
    end
  end

  // Register stage; a software reset clears the soft reset flag, only RST_B sets it again
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      bank_r <= `RST_BANK;
      pch_r <= `RST_PCH;
      acc_r <= `RST_ACC;
      option_r <= `RST_OPTION;
      ptr_r[0] <= `RST_PTR;
      ptr_r[1] <= `RST_PTR;
      wr_en_r <= 1'b0;
      wr_addr_r <= '0;
      wr_data_r <= 8'h00;
      soft_flag_b_r <= 1'b1;
      rst_req_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      bank_r <= bank_nxt;
      pch_r <= pch_nxt;
      acc_r <= acc_nxt;
      option_r <= option_nxt;
      ptr_r[0] <= ptr_nxt[0];
      ptr_r[1] <= ptr_nxt[1];
      wr_en_r <= wr_en_nxt;
      wr_addr_r <= wr_addr_nxt;
      wr_data_r <= wr_data_nxt;
      soft_flag_b_r <= soft_flag_b_nxt;
      rst_req_r <= rst_req_nxt;
      done_r <= done_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign BANK_SELECT = bank_r;
  assign PC_HIGH_LATCH = pch_r;
  assign ACCUM = acc_r;
  assign OPTION_CFG = option_r;
  assign POINTER0 = ptr_r[0];
  assign POINTER1 = ptr_r[1];
  assign FILE_WR_EN = wr_en_r;
  assign FILE_WR_ADDR = wr_addr_r;
  assign FILE_WR_DATA = wr_data_r;
  // No status write from this group
  assign STATUS_WR_EN = 1'b0;
  assign SOFT_RESET_FLAG_B = soft_flag_b_r;
  assign DEVICE_RESET_REQ = rst_req_r;
  assign INSTR_DONE = done_r;

endmodule // move_literal_exec
`default_nettype wire

//--- common/move_literal_params.svh
// Constants for the literal, store and indirect instruction group
// Assumes a 14-bit instruction word and a 16-bit linear data space
`ifndef MOVE_LITERAL_PARAMS_SVH
`define MOVE_LITERAL_PARAMS_SVH

// Opcode masks and match values
`define OPC_LOAD_BANK_MASK 14'h3FE0
`define OPC_LOAD_BANK_VAL 14'h0020
`define OPC_LOAD_PCH_MASK 14'h3F80
`define OPC_LOAD_PCH_VAL 14'h3180
`define OPC_LOAD_ACC_MASK 14'h3F00
`define OPC_LOAD_ACC_VAL 14'h3000
`define OPC_STORE_MASK 14'h3F80
`define OPC_STORE_VAL 14'h0080
`define OPC_STORE_IND_MASK 14'h3FF8
`define OPC_STORE_IND_VAL 14'h0018
`define OPC_STORE_REL_MASK 14'h3F80
`define OPC_STORE_REL_VAL 14'h3F80
`define OPC_NOP 14'h0000
`define OPC_OPTION 14'h0062
`define OPC_SOFT_RESET 14'h0001

// Operand field positions
`define FLD_BANK_MSB 4
`define FLD_PCH_MSB 6
`define FLD_ACC_MSB 7
`define FLD_FILE_MSB 6
`define FLD_MODE_MSB 1
`define FLD_PTR_SEL_IND 2
`define FLD_PTR_SEL_REL 6
`define FLD_OFFSET_MSB 5

// Core register addresses inside every bank
`define ADDR_IND_PORT0 7'h00
`define ADDR_IND_PORT1 7'h01
`define ADDR_PTR0_LO 7'h04
`define ADDR_PTR0_HI 7'h05
`define ADDR_PTR1_LO 7'h06
`define ADDR_PTR1_HI 7'h07
`define ADDR_BANK 7'h08
`define ADDR_ACC 7'h09
`define ADDR_PCH 7'h0A

// Reset values
`define RST_BANK 5'h00
`define RST_PCH 7'h00
`define RST_ACC 8'h00
`define RST_OPTION 8'hFF
`define RST_PTR 16'h0000

`endif

//--- common/move_literal_pkg.sv
// Types for the literal, store and indirect instruction group
// Assumes nothing beyond the constants header
package move_literal_pkg;

  // Decoded instruction of this group
  typedef enum logic [3:0] {
    OP_OTHER,
    OP_NOP,
    OP_LOAD_BANK,
    OP_LOAD_PCH,
    OP_LOAD_ACC,
    OP_STORE,
    OP_STORE_IND,
    OP_STORE_REL,
    OP_OPTION,
    OP_SOFT_RESET
  } op_e;

  // Pointer update modes
  typedef enum logic [1:0] {
    PTR_PRE_INC,
    PTR_PRE_DEC,
    PTR_POST_INC,
    PTR_POST_DEC
  } ptr_mode_e;

endpackage

//--- rtl/instr_decode.sv
// Combinational decoder for the literal, store and indirect group
// Assumes a 14-bit instruction word presented by the fetch stage
`timescale 1ns/1ns
`default_nettype none
`include "move_literal_params.svh"

module instr_decode (
  input wire logic [13:0] instr,
  output var move_literal_pkg::op_e op
);

  // Match each opcode pattern; anything else belongs elsewhere
  always_comb begin
    if (instr == `OPC_NOP) begin
      op = move_literal_pkg::OP_NOP;
    end else if (instr == `OPC_SOFT_RESET) begin
      op = move_literal_pkg::OP_SOFT_RESET;
    end else if (instr == `OPC_OPTION) begin
      op = move_literal_pkg::OP_OPTION;
    end else if ((instr & `OPC_STORE_IND_MASK) == `OPC_STORE_IND_VAL) begin
      op = move_literal_pkg::OP_STORE_IND;
    end else if ((instr & `OPC_LOAD_BANK_MASK) == `OPC_LOAD_BANK_VAL) begin
      op = move_literal_pkg::OP_LOAD_BANK;
    end else if ((instr & `OPC_STORE_MASK) == `OPC_STORE_VAL) begin
      op = move_literal_pkg::OP_STORE;
    end else if ((instr & `OPC_STORE_REL_MASK) == `OPC_STORE_REL_VAL) begin
      op = move_literal_pkg::OP_STORE_REL;
    end else if ((instr & `OPC_LOAD_PCH_MASK) == `OPC_LOAD_PCH_VAL) begin
      op = move_literal_pkg::OP_LOAD_PCH;
    end else if ((instr & `OPC_LOAD_ACC_MASK) == `OPC_LOAD_ACC_VAL) begin
      op = move_literal_pkg::OP_LOAD_ACC;
    end else begin
      op = move_literal_pkg::OP_OTHER;
    end
  end

endmodule // instr_decode
`default_nettype wire

//--- rtl/ptr_calc.sv
// Effective address and updated value of one indirect pointer
// Assumes the caller decides whether the pointer is selected
`timescale 1ns/1ns
`default_nettype none

module ptr_calc #(
  parameter int PTR_W = 16
) (
  input wire logic [PTR_W-1:0] ptr,
  input wire logic by_offset,
  input wire move_literal_pkg::ptr_mode_e mode,
  input wire logic [5:0] offset,
  output logic [PTR_W-1:0] eff_addr,
  output logic [PTR_W-1:0] ptr_new
);

  logic [PTR_W-1:0] plus_one;
  logic [PTR_W-1:0] minus_one;
  logic [PTR_W-1:0] offset_ext;

  assign plus_one = ptr + PTR_W'(1);
  assign minus_one = ptr - PTR_W'(1);
  assign offset_ext = {{(PTR_W-6){offset[5]}}, offset};

  always_comb begin
    if (by_offset) begin
      eff_addr = ptr + offset_ext;
      ptr_new = ptr;
    end else begin
      unique case (mode)
        move_literal_pkg::PTR_PRE_INC: begin
          eff_addr = plus_one;
          ptr_new = plus_one;
        end
        move_literal_pkg::PTR_PRE_DEC: begin
          eff_addr = minus_one;
          ptr_new = minus_one;
        end
        move_literal_pkg::PTR_POST_INC: begin
          eff_addr = ptr;
          ptr_new = plus_one;
        end
        move_literal_pkg::PTR_POST_DEC: begin
          eff_addr = ptr;
          ptr_new = minus_one;
        end
      endcase
    end
  end

endmodule // ptr_calc
`default_nettype wire

//--- tb/move_literal_exec_properties.sv
// Checker for the literal, store and indirect instruction unit
// Assumes only the unit's ports and its synchronous active-low reset
`timescale 1ns/1ns
`default_nettype none
module move_literal_exec_properties #(
  parameter int PTR_W = 16
) (
  input wire logic CORE_CLK,
  input wire logic RST_B,
  input wire logic INSTR_VALID,
  input wire logic [13:0] INSTR_WORD,
  input wire logic [4:0] BANK_SELECT,
  input wire logic [6:0] PC_HIGH_LATCH,
  input wire logic [7:0] ACCUM,
  input wire logic [7:0] OPTION_CFG,
  input wire logic [PTR_W-1:0] POINTER0,
  input wire logic FILE_WR_EN,
  input wire logic [PTR_W-1:0] FILE_WR_ADDR,
  input wire logic [7:0] FILE_WR_DATA,
  input wire logic STATUS_WR_EN,
  input wire logic SOFT_RESET_FLAG_B,
  input wire logic DEVICE_RESET_REQ,
  input wire logic INSTR_DONE
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);
  // Literal loads land one cycle after the word is taken
  a_bank_load: assert property (INSTR_VALID && (INSTR_WORD & 14'h3FE0) == 14'h0020
    |=> BANK_SELECT == $past(INSTR_WORD[4:0])) else $error("bank load wrong");
  a_pch_load: assert property (INSTR_VALID && (INSTR_WORD & 14'h3F80) == 14'h3180
    |=> PC_HIGH_LATCH == $past(INSTR_WORD[6:0])) else $error("pc high load wrong");
  a_acc_load: assert property (INSTR_VALID && (INSTR_WORD & 14'h3F00) == 14'h3000
    |=> ACCUM == $past(INSTR_WORD[7:0])) else $error("acc load wrong");
  a_store_direct: assert property (INSTR_VALID && (INSTR_WORD & 14'h3F80) == 14'h0080
    && INSTR_WORD[6:1] != 6'h00 |=> FILE_WR_EN && FILE_WR_DATA == $past(ACCUM)
    && FILE_WR_ADDR == PTR_W'({$past(BANK_SELECT), $past(INSTR_WORD[6:0])}))
    else $error("direct store wrong");
  a_preinc_ptr: assert property (INSTR_VALID && INSTR_WORD == 14'h0018
    |=> FILE_WR_EN && FILE_WR_ADDR == $past(POINTER0) + 1'b1 && POINTER0 == FILE_WR_ADDR)
    else $error("pre-increment store wrong");
  a_option_load: assert property (INSTR_VALID && INSTR_WORD == 14'h0062
    |=> OPTION_CFG == $past(ACCUM)) else $error("option load wrong");
  a_soft_reset: assert property (INSTR_VALID && INSTR_WORD == 14'h0001
    |=> DEVICE_RESET_REQ && !SOFT_RESET_FLAG_B
    ##1 (DEVICE_RESET_REQ == $past(INSTR_VALID && INSTR_WORD == 14'h0001)))
    else $error("software reset wrong");
  a_flag_hold: assert property (!SOFT_RESET_FLAG_B |=> !SOFT_RESET_FLAG_B)
    else $error("reset flag rose");
  a_idle_quiet: assert property (!INSTR_VALID
    |=> !INSTR_DONE && !FILE_WR_EN && !DEVICE_RESET_REQ) else $error("activity when idle");
  a_no_status: assert property (!STATUS_WR_EN)
    else $error("status write seen");
  // Main scenarios reached
  c_soft_reset: cover property (DEVICE_RESET_REQ);
  c_indirect: cover property (INSTR_VALID && INSTR_WORD[13:3] == 11'h003);
  c_back2back: cover property (INSTR_VALID ##1 INSTR_VALID);
endmodule // move_literal_exec_properties

bind move_literal_exec move_literal_exec_properties #(.PTR_W(PTR_W)) props (
  .CORE_CLK, .RST_B, .INSTR_VALID, .INSTR_WORD, .BANK_SELECT, .PC_HIGH_LATCH, .ACCUM,
  .OPTION_CFG, .POINTER0, .FILE_WR_EN, .FILE_WR_ADDR, .FILE_WR_DATA, .STATUS_WR_EN,
  .SOFT_RESET_FLAG_B, .DEVICE_RESET_REQ, .INSTR_DONE);
`default_nettype wire

//--- tb/tb.sv
// Self-checking bench for the literal, store and indirect instruction unit
// Assumes the package and the design files are compiled first
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic valid = 1'b0;
  logic [13:0] word = 14'h0000;
  logic [4:0] bsel, e_bank;
  logic [6:0] pchl, e_pch;
  logic [7:0] accq, optq, wd, e_acc, e_opt, e_data;
  logic [15:0] ptr0, ptr1, wa, e_addr;
  logic [15:0] e_p [2];
  logic we, swe, flag_b, rq, done, e_we, e_flag, e_rq, e_done;
  logic [31:0] r;
  integer seed, n_fail = 0, total_checks = 0;
  logic [13:0] corner [16] = '{14'h0000, 14'h0100, 14'h003F, 14'h31FF, 14'h30FF,
    14'h0085, 14'h0084, 14'h001A, 14'h001B, 14'h30A5, 14'h0062, 14'h0081, 14'h00FF,
    14'h0018, 14'h0088, 14'h008A};

  move_literal_exec dut (.CORE_CLK(clk), .RST_B(rst_b), .INSTR_VALID(valid),
    .INSTR_WORD(word), .BANK_SELECT(bsel), .PC_HIGH_LATCH(pchl), .ACCUM(accq),
    .OPTION_CFG(optq), .POINTER0(ptr0), .POINTER1(ptr1), .FILE_WR_EN(we),
    .FILE_WR_ADDR(wa), .FILE_WR_DATA(wd), .STATUS_WR_EN(swe),
    .SOFT_RESET_FLAG_B(flag_b), .DEVICE_RESET_REQ(rq), .INSTR_DONE(done));

  // Clock, 8 ns period
  always #4 clk = ~clk;

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic cmp(input string name, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      n_fail++;
    end
  endtask

  // Expected core registers after either kind of reset
  task automatic exp_reset();
    {e_bank, e_pch, e_acc, e_opt} = {5'h00, 7'h00, 8'h00, 8'hFF};
    e_p = '{16'h0000, 16'h0000};
  endtask

  // Presents one word and updates the expected state at the taking edge
  task automatic issue(input logic [13:0] w);
    logic [15:0] p;
    valid <= 1'b1;
    word <= w;
    @(posedge clk);
    p = e_p[w[2]];
    e_we = 1'b0;
    e_rq = 1'b0;
    e_done = 1'b1;
    e_data = e_acc;
    if (w == 14'h0001) begin
      exp_reset();
      e_flag = 1'b0;
      e_rq = 1'b1;
    end else if (w == 14'h0062) e_opt = e_acc;
    else if ((w & 14'h3FE0) == 14'h0020) e_bank = w[4:0];
    else if ((w & 14'h3F80) == 14'h3180) e_pch = w[6:0];
    else if ((w & 14'h3F00) == 14'h3000) e_acc = w[7:0];
    else if ((w & 14'h3F80) == 14'h0080) begin
      e_we = 1'b1;
      e_addr = (w[6:1] == 6'h00) ? e_p[w[0]] : {4'h0, e_bank, w[6:0]};
      if (w[6:0] == 7'h08) e_bank = e_acc[4:0];
      if (w[6:0] == 7'h0A) e_pch = e_acc[6:0];
      if (w[6:2] == 5'h01) e_p[w[1]] = w[0] ? {e_acc, e_p[w[1]][7:0]} : {e_p[w[1]][15:8], e_acc};
    end else if ((w & 14'h3FF8) == 14'h0018) begin
      e_we = 1'b1;
      e_p[w[2]] = w[0] ? p - 16'h0001 : p + 16'h0001;
      e_addr = w[1] ? p : e_p[w[2]];
    end else if ((w & 14'h3F80) == 14'h3F80) begin
      e_we = 1'b1;
      e_addr = e_p[w[6]] + {{10{w[5]}}, w[5:0]};
    end else if (w != 14'h0000) e_done = 1'b0;
  endtask

  // Drops the request and compares every output at mid-cycle, the write address and data only when a write is expected
  task automatic chk();
    valid <= 1'b0;
    @(negedge clk);
    cmp("bank", e_bank, bsel);
    cmp("pch", e_pch, pchl);
    cmp("acc", e_acc, accq);
    cmp("option", e_opt, optq);
    cmp("ptr0", e_p[0], ptr0);
    cmp("ptr1", e_p[1], ptr1);
    cmp("wr_en", e_we, we);
    if (e_we) cmp("wr_addr", e_addr, wa);
    if (e_we) cmp("wr_data", e_data, wd);
    cmp("status", 16'h0000, swe);
    cmp("flag_b", e_flag, flag_b);
    cmp("reset_req", e_rq, rq);
    cmp("done", e_done, done);
    @(posedge clk);
  endtask

  task automatic run(input logic [13:0] w);
    issue(w);
    chk();
  endtask

  initial begin
    seed = 32'hF0D41D21;
    exp_reset();
    {e_we, e_flag, e_rq, e_done} = 4'b0100;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    chk();
    foreach (corner[i]) run(corner[i]);
    issue(14'h3012);
    run(14'h009C);
    $display("corner test done");
    repeat (30) begin
      r = $random(seed);
      run({6'h30, r[7:1], 1'b1});
      run({11'h010, r[8], 1'b1, 1'b1});
      run({6'h30, r[16:9]});
      run({11'h010, r[8], 1'b1, 1'b0});
      run({6'h30, r[24:17]});
      run(r[25] ? {7'h7F, r[8], r[31:26]} : {11'h003, r[8], r[27:26]});
      run({8'h01, r[5:0]});
      run({9'h001, r[12:8]});
      run({7'h63, r[22:16]});
    end
    $display("random test done");
    run(14'h0001);
    run(14'h0000);
    // Mid-run reset sets the soft reset flag again
    rst_b <= 1'b0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    exp_reset();
    {e_we, e_flag, e_rq, e_done} = 4'b0100;
    chk();
    run(14'h0062);
    $display("soft reset test done");
    finish_test();
  end

  // Guards against a hung run
  initial begin
    #100000;
    n_fail++;
    finish_test();
  end
endmodule // tb
`default_nettype wire
